// *** rtl/charger_pkg.sv ***
package charger_pkg;
   localparam logic [7:0] MODE_CMD_OFFSET = 8'h12;
   localparam logic [7:0] INPUT_LIMIT_OFFSET = 8'h3F;
   localparam int MODE_INHIBIT_BIT = 0;
   localparam int MODE_RESTORE_BIT = 2;
   localparam int MODE_ZERO_BIT = 3;
   localparam int MODE_ADP_MASK_BIT = 4;
   localparam int MODE_BAT_MASK_BIT = 5;
   localparam int MODE_FAIL_MASK_BIT = 6;
   localparam int MODE_RELEARN_BIT = 8;
   localparam int MODE_HOTSTOP_BIT = 10;
   localparam logic [15:0] VOLTAGE_DEFAULT = 16'h4B00;
   localparam logic [15:0] CURRENT_DEFAULT = 16'h0080;
   localparam logic [15:0] INPUT_LIMIT_DEFAULT = 16'h0100;
   localparam logic [15:0] INPUT_LIMIT_MAX = 16'h1F80;
   localparam logic [15:0] INPUT_LIMIT_KEEP = 16'h1F80;
   localparam logic [15:0] INPUT_LIMIT_MIN = 16'h0100;
   localparam logic [15:0] MODE_USED_MASK = 16'h057D;
   localparam logic [15:0] MODE_RESET = 16'h0400;

   typedef struct packed
   {
      logic wr;
      logic [7:0] cmd;
      logic [15:0] data;
   } host_write_t;

   typedef struct packed
   {
      logic supply_fail;
      logic battery_present;
      logic adapter_present;
   } status_in_t;
endpackage

// *** rtl/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
   import charger_pkg::*;
#(
   parameter int WIDTH = 1
)
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // pins in, filtered level out
   input wire logic [WIDTH-1:0] pin_i,
   output logic [WIDTH-1:0] level_o
);
   typedef struct packed
   {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] lvl;
   } sync_state_t;

   sync_state_t st_r;
   sync_state_t st_nxt;

   always_comb
   begin
      st_nxt = st_r;
      st_nxt.s1 = pin_i;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      // accept per bit only once stages two and three agree
      for (int i = 0; i < WIDTH; i++)
      begin
         if (st_r.s2[i] == st_r.s3[i])
         begin
            st_nxt.lvl[i] = st_r.s3[i];
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         st_r <= '0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign level_o = st_r.lvl;
endmodule

// *** rtl/charger_mode_ctrl.sv ***
`timescale 1ns/1ps
module charger_mode_ctrl
   import charger_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic reset_i,
   // decoded host write, pulsed when a write-word ends
   input wire host_write_t host_wr_i,
   // alarm warning and new setpoint pair events
   input wire logic alarm_set_i,
   input wire logic alarm_clear_i,
   // status pins from analog side
   input wire status_in_t status_i,
   input wire logic adapter_above_battery_voltage_i,
   input wire logic overtemp_latch_i,
   input wire logic thermistor_over_i,
   // setpoints and latches
   output logic [15:0] charge_voltage_setpoint_o,
   output logic [15:0] charge_current_setpoint_o,
   output logic [15:0] input_limit_setpoint_o,
   output logic [15:0] mode_command_o,
   output logic charge_off_latch_o,
   output logic overtemp_latch_o,
   output logic alarm_latch_o,
   // power path and regulator
   output logic system_source_switch_o,
   output logic battery_path_switch_o,
   output logic regulator_enable_o,
   // interrupt
   output logic int_n_o
);
   typedef struct packed
   {
      logic [15:0] mode;
      logic [15:0] volt;
      logic [15:0] curr;
      logic [15:0] ilim;
      logic chg_off;
      logic hot;
      logic alarm;
      status_in_t prev;
      logic src_sw;
      logic bat_sw;
      logic reg_en;
      logic int_n;
   } ctrl_state_t;

   localparam ctrl_state_t RESET_STATE = '{
      mode: MODE_RESET,
      volt: VOLTAGE_DEFAULT,
      curr: CURRENT_DEFAULT,
      ilim: INPUT_LIMIT_DEFAULT,
      chg_off: 1'b0,
      hot: 1'b0,
      alarm: 1'b0,
      prev: '0,
      src_sw: 1'b1,
      bat_sw: 1'b0,
      reg_en: 1'b0,
      int_n: 1'b1
   };

   ctrl_state_t st_r;
   ctrl_state_t st_nxt;
   status_in_t stat_s;
   logic [1:0] misc_s;
   logic adp_above;
   logic thm_hot;
   logic [15:0] ilim_req;
   logic [15:0] wdata;

   // analog comparator and status pins come from outside this clock
   pin_sync #(
      .WIDTH(5)
   ) u_sync (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .pin_i({status_i, adapter_above_battery_voltage_i, overtemp_latch_i}),
      .level_o({stat_s, misc_s})
   );

   assign adp_above = misc_s[1];
   assign thm_hot = misc_s[0];

   always_comb
   begin
      st_nxt = st_r;
      wdata = host_wr_i.data & MODE_USED_MASK;
      ilim_req = host_wr_i.data & INPUT_LIMIT_KEEP;
      // overtemp latch: set has priority over clears
      if (!stat_s.battery_present)
      begin
         st_nxt.hot = 1'b0;
         st_nxt.alarm = 1'b0;
      end
      if (alarm_clear_i)
      begin
         st_nxt.alarm = 1'b0;
      end
      // whole word takes effect together at the end of the write
      if (host_wr_i.wr && host_wr_i.cmd == MODE_CMD_OFFSET)
      begin
         st_nxt.mode = wdata;
         st_nxt.chg_off = wdata[MODE_INHIBIT_BIT];
         if (wdata[MODE_RESTORE_BIT])
         begin
            st_nxt.volt = VOLTAGE_DEFAULT;
            st_nxt.curr = CURRENT_DEFAULT;
            st_nxt.hot = 1'b0;
            st_nxt.alarm = 1'b0;
         end
         if (wdata[MODE_ZERO_BIT])
         begin
            st_nxt.volt = '0;
            st_nxt.curr = '0;
         end
      end
      if (host_wr_i.wr && host_wr_i.cmd == INPUT_LIMIT_OFFSET)
      begin
         if (ilim_req > INPUT_LIMIT_MAX)
         begin
            st_nxt.ilim = INPUT_LIMIT_MAX;
         end
         else if (host_wr_i.data != 16'h0000 && ilim_req < INPUT_LIMIT_MIN)
         begin
            st_nxt.ilim = INPUT_LIMIT_MIN;
         end
         else
         begin
            st_nxt.ilim = ilim_req;
         end
      end
      // no battery holds power-on setpoints and the hotstop mode bit over any write, so no one-cycle glitch
      if (!stat_s.battery_present)
      begin
         st_nxt.volt = VOLTAGE_DEFAULT;
         st_nxt.curr = CURRENT_DEFAULT;
         st_nxt.ilim = INPUT_LIMIT_DEFAULT;
         st_nxt.mode[MODE_HOTSTOP_BIT] = 1'b1;
      end
      if (thm_hot && stat_s.battery_present)
      begin
         st_nxt.hot = 1'b1;
      end
      if (alarm_set_i)
      begin
         st_nxt.alarm = 1'b1;
      end
      // power path selection
      if (st_r.mode[MODE_RELEARN_BIT] || !adp_above)
      begin
         st_nxt.src_sw = 1'b1;
         st_nxt.bat_sw = 1'b0;
      end
      else
      begin
         st_nxt.src_sw = 1'b0;
         st_nxt.bat_sw = 1'b1;
      end
      st_nxt.reg_en = !st_r.chg_off && !st_r.alarm
         && !(st_r.hot && st_r.mode[MODE_HOTSTOP_BIT]);
      // edges of unmasked status bits; int_n low for one cycle per edge
      st_nxt.prev = stat_s;
      if ((stat_s.adapter_present != st_r.prev.adapter_present && !st_r.mode[MODE_ADP_MASK_BIT])
         || (stat_s.battery_present != st_r.prev.battery_present && !st_r.mode[MODE_BAT_MASK_BIT])
         || (stat_s.supply_fail != st_r.prev.supply_fail && !st_r.mode[MODE_FAIL_MASK_BIT]))
      begin
         st_nxt.int_n = 1'b0;
      end
      else
      begin
         st_nxt.int_n = 1'b1;
      end
   end

   always_ff @(posedge ref_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         st_r <= RESET_STATE;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign charge_voltage_setpoint_o = st_r.volt;
   assign charge_current_setpoint_o = st_r.curr;
   assign input_limit_setpoint_o = st_r.ilim;
   assign mode_command_o = st_r.mode;
   assign charge_off_latch_o = st_r.chg_off;
   assign overtemp_latch_o = st_r.hot;
   assign alarm_latch_o = st_r.alarm;
   assign system_source_switch_o = st_r.src_sw;
   assign battery_path_switch_o = st_r.bat_sw;
   assign regulator_enable_o = st_r.reg_en;
   assign int_n_o = st_r.int_n;
endmodule

// *** testbench/charger_props.sv ***
`timescale 1ns/1ps
module charger_props
   import charger_pkg::*;
(
   // clock, reset and inputs
   input wire logic ref_clk_i,
   input wire logic reset_i,
   input wire host_write_t host_wr_i,
   input wire logic alarm_set_i,
   input wire status_in_t status_i,
   // outputs
   input wire logic [15:0] charge_voltage_setpoint_o,
   input wire logic [15:0] charge_current_setpoint_o,
   input wire logic [15:0] input_limit_setpoint_o,
   input wire logic [15:0] mode_command_o,
   input wire logic charge_off_latch_o,
   input wire logic overtemp_latch_o,
   input wire logic alarm_latch_o,
   input wire logic int_n_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (reset_i);
   wire logic [15:0] d = host_wr_i.data;
   wire logic mw = host_wr_i.wr && host_wr_i.cmd == 8'h12;
   wire logic lw = host_wr_i.wr && host_wr_i.cmd == 8'h3F;
   // pins pass a synchronizer, so require six steady samples
   wire logic bp = status_i.battery_present;
   a_inhibit_set: assert property (mw && d[0] |=> charge_off_latch_o)
      else $error("latch not set");
   a_inhibit_clr: assert property (mw && !d[0] |=> !charge_off_latch_o)
      else $error("latch not clear");
   a_latch_hold: assert property (!mw |=> $stable(charge_off_latch_o))
      else $error("latch moved");
   a_zero_pts: assert property (bp[*6] ##0 (mw && d[3]) |=> charge_current_setpoint_o == 16'h0000
      && charge_voltage_setpoint_o == 16'h0000) else $error("setpoints not zero");
   a_restore_pts: assert property (bp[*6] ##0 (mw && d[2] && !d[3] && !alarm_set_i) |=> !alarm_latch_o
      && charge_voltage_setpoint_o == 16'h4B00 && charge_current_setpoint_o == 16'h0080) else $error("no restore");
   a_ilim_min: assert property (bp[*6] ##0 (lw && d inside {[16'h0001:16'h0100]}) |=>
      input_limit_setpoint_o == 16'h0100) else $error("limit floor");
   a_ilim_mask: assert property (bp[*6] ##0 (lw && (d & 16'h1F00) != 16'h0000) |=>
      input_limit_setpoint_o == ($past(d) & 16'h1F80)) else $error("limit mask");
   a_battery_voltage_gone: assert property (!bp[*6] |=> input_limit_setpoint_o == 16'h0100 && !overtemp_latch_o)
      else $error("no battery defaults");
   a_int_pulse: assert property ($fell(int_n_o) |=> int_n_o)
      else $error("interrupt too long");
   a_mode_unused: assert property ((mode_command_o & 16'hFA82) == 16'h0000)
      else $error("unused mode bit");
   c_zero: cover property (mw && d[3]);
   c_int: cover property ($fell(int_n_o));
   c_battery_voltage: cover property ($fell(bp));
endmodule

bind charger_mode_ctrl charger_props i_props (.ref_clk_i, .reset_i, .host_wr_i, .alarm_set_i, .status_i,
   .charge_voltage_setpoint_o, .charge_current_setpoint_o, .input_limit_setpoint_o, .mode_command_o,
   .charge_off_latch_o, .overtemp_latch_o, .alarm_latch_o, .int_n_o);

// *** testbench/smbus_host_model.sv ***
`timescale 1ns/1ps
module smbus_host_model
   import charger_pkg::*;
(
   // clock in, decoded write out
   input wire logic ref_clk_i,
   output host_write_t host_wr_o
);
   initial host_wr_o = '0;
   // random idle gap so the host is sometimes slow
   task automatic write(input logic [7:0] c, input logic [15:0] d);
      repeat (1 + $urandom_range(2)) @(posedge ref_clk_i);
      #2 host_wr_o = '{1'b1, c, d};
      @(posedge ref_clk_i);
      #2 host_wr_o = '{1'b0, ~c, ~d};
   endtask
endmodule

// *** testbench/charger_mode_and_interrupt_ctrl_tb_top.sv ***
`timescale 1ns/1ps
module charger_mode_and_interrupt_ctrl_tb_top
   import charger_pkg::*;
;
   logic ref_clk_i = 0, reset_i = 1, alarm_set_i = 0, adapter_above_battery_voltage_i = 0, overtemp_latch_i = 0;
   logic thermistor_over_i = 0, off_l, hot_l, alm_l, src_sw, bat_sw, reg_en, int_n, seen = 0;
   status_in_t status_i = 3'b010;
   host_write_t host_wr;
   logic [15:0] volt, curr, ilim, mode, d;
   logic [18:0] e, q[$];
   int bad_count = 0, n_tests = 0, cyc = 0, ints = 0, n;
   // {cmd, data, select, expected}
   logic [47:0] tbl[9] = '{48'h12_0008_01_0000, 48'h12_0004_00_4B00, 48'h12_000C_00_0000,
      48'h12_0004_01_0080, 48'h12_0000_01_0080, 48'h3F_0001_02_0100, 48'h3F_FFFF_02_1F80,
      48'h3F_1234_02_1200, 48'h55_FFFF_02_1200};
   always #12.5 ref_clk_i = ~ref_clk_i;
   charger_mode_ctrl i_dut (.ref_clk_i, .reset_i, .host_wr_i(host_wr), .alarm_set_i, .alarm_clear_i(1'b0),
      .status_i, .adapter_above_battery_voltage_i, .overtemp_latch_i, .thermistor_over_i, .charge_voltage_setpoint_o(volt),
      .charge_current_setpoint_o(curr), .input_limit_setpoint_o(ilim), .mode_command_o(mode),
      .charge_off_latch_o(off_l), .overtemp_latch_o(hot_l), .alarm_latch_o(alm_l), .system_source_switch_o(src_sw),
      .battery_path_switch_o(bat_sw), .regulator_enable_o(reg_en), .int_n_o(int_n));
   smbus_host_model i_host (.ref_clk_i, .host_wr_o(host_wr));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("mismatches=%0d checks=%0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [47:0] x);
      q.push_back({x[18:16], x[15:0]});
      i_host.write(x[47:40], x[39:24]);
   endtask
   task automatic pause(input int k);
      repeat (k) @(posedge ref_clk_i);
      #2;
   endtask
   always @(posedge ref_clk_i)
   begin
      seen <= host_wr.wr;
      cyc <= cyc + 1;
      ints <= ints + int'(int_n === 1'b0);
      if (cyc == 2000)
      begin
         bad_count++;
         report_and_stop();
      end
   end
   // result shows one edge after the write is taken
   always @(negedge ref_clk_i)
      if (seen)
      begin
         e = q.pop_front();
         chk(e[18:16] == 0 ? volt : e[18:16] == 1 ? curr : e[18:16] == 2 ? ilim : {off_l, mode[14:0]}, e[15:0]);
      end
   initial
   begin
      void'($urandom(32'hBC32));
      pause(16);
      reset_i = 0;
      pause(8);
      chk(mode, 16'h0400);
      chk(ilim, 16'h0100);
      chk({volt ^ 16'h4B00} | {curr ^ 16'h0080} | {15'h0, ~int_n}, 16'h0000);
      foreach (tbl[i]) wr(tbl[i]);
      repeat (8)
      begin
         d = 16'($urandom) & 16'hFFF3;
         wr({8'h12, d, 8'h04, d[0], d[14:0] & 15'h057D});
      end
      for (int b = 0; b < 3; b++)
      begin
         wr({8'h12, 16'h0000, 8'h04, 16'h0000});
         n = ints;
         status_i[b] = ~status_i[b];
         pause(10);
         if (b == 1) chk(ilim, 16'h0100);
         // battery gone forces the overtemp stop bit back on
         wr({8'h12, 16'h0010 << b, 8'h04, (16'h0010 << b) | (b == 1 ? 16'h0400 : 16'h0000)});
         status_i[b] = ~status_i[b];
         pause(10);
         chk(16'(ints - n), 16'h0001);
      end
      for (int i = 0; i < 3; i++)
      begin
         wr({8'h12, 7'h0, i == 2, 8'h00, 8'h04, 7'h0, i == 2, 8'h00});
         adapter_above_battery_voltage_i = i != 1;
         thermistor_over_i = 1'($urandom);
         pause(8);
         chk({14'h0, src_sw, bat_sw}, i == 0 ? 16'h0001 : 16'h0002);
      end
      wr({8'h12, 16'h0400, 8'h04, 16'h0400});
      overtemp_latch_i = 1;
      pause(8);
      chk({13'h0, hot_l, alm_l, reg_en}, 16'h0004);
      // same latch with the stop bit off lets the regulator run
      wr({8'h12, 16'h0000, 8'h04, 16'h0000});
      pause(3);
      chk({13'h0, hot_l, alm_l, reg_en}, 16'h0005);
      alarm_set_i = 1;
      pause(1);
      alarm_set_i = 0;
      pause(3);
      chk({13'h0, hot_l, alm_l, reg_en}, 16'h0006);
      overtemp_latch_i = 0;
      pause(6);
      wr({8'h12, 16'h0004, 8'h00, 16'h4B00});
      pause(2);
      chk({14'h0, hot_l, alm_l}, 16'h0000);
      report_and_stop();
   end
endmodule
